// ===== design/caf_pkg.sv
package caf_pkg;

   // address map, byte addresses on the 12-bit bus window
   localparam int unsigned ADDR_W               = 12;
   localparam logic [11:0] OFF_MODULE_CONTROL   = 12'h000;
   localparam logic [11:0] OFF_MASK_BASE        = 12'h040;
   localparam logic [11:0] OFF_FILTER_CTRL_BASE = 12'h080;
   localparam logic [11:0] OFF_FILTER_WORD_BASE = 12'h100;

   // sizes
   localparam int unsigned NUM_FILTERS    = 32;
   localparam int unsigned NUM_MASKS      = 4;
   localparam int unsigned NUM_CTRL_WORDS = 8;
   localparam int unsigned NUM_DATA_CMP   = 18;

   // module control fields
   localparam int unsigned CON_ENABLE_BIT    = 15;
   localparam int unsigned CON_HALT_IDLE_BIT = 13;
   localparam int unsigned CON_ACTIVE_BIT    = 11;
   localparam int unsigned CON_COUNT_LSB     = 0;
   localparam int unsigned COUNT_W           = 5;
   localparam logic [4:0]  COUNT_MAX         = 5'h12;

   // filter control lane fields (one byte per filter)
   localparam int unsigned CTL_EN_BIT   = 7;
   localparam int unsigned CTL_MASK_CHOICE_LSB = 5;
   localparam int unsigned CTL_DESTINATION_FIFO_CHOICE_LSB = 0;

   // identifier word fields
   localparam int unsigned ID_SID_LSB  = 21;
   localparam int unsigned ID_TYPE_BIT = 19;
   localparam int unsigned ID_EID_LSB  = 0;

   // writable bits of each word
   localparam logic [31:0] CON_WRITE_MASK  = 32'h0000_a01f;
   localparam logic [31:0] ID_WRITE_MASK   = 32'hffeb_ffff;
   localparam logic [31:0] MASK_WRITE_MASK = 32'hffe3_ffff;

   // reset values
   localparam logic        CON_ENABLE_RST = 1'b1;
   localparam logic        CON_HALT_RST   = 1'b0;
   localparam logic [4:0]  COUNT_RST      = 5'h00;
   localparam logic [7:0]  CTL_LANE_RST   = 8'h00;
   localparam logic [31:0] ID_WORD_RST    = 32'h0000_0000;
   localparam logic [31:0] MASK_WORD_RST  = 32'h0000_0000;

   // received message as handed over by the protocol engine
   typedef struct packed {
      logic        is_ext;
      logic [10:0] standard_id_pattern;
      logic [17:0] extended_id_pattern;
      logic [23:0] data;
   } caf_msg_s;

   // one filter lane of a filter control word
   typedef struct packed {
      logic       en;
      logic [1:0] mask_choice;
      logic [4:0] destination_fifo_choice;
   } caf_flt_cfg_s;

   // identifier word and mask word layout
   typedef struct packed {
      logic [10:0] standard_id_pattern;
      logic        rsv_hi;
      logic        id_type;
      logic        rsv_lo;
      logic [17:0] extended_id_pattern;
   } caf_id_s;

   // acceptance result
   typedef struct packed {
      logic       hit;
      logic [4:0] filter;
      logic [4:0] fifo;
   } caf_result_s;

   // bus slave states
   typedef enum logic [1:0] {
      APB_IDLE = 2'b01,
      APB_ACK  = 2'b10
   } caf_apb_e;

endpackage : caf_pkg

// ===== design/caf_filter_cmp.sv
`timescale 1ns/10ps
module caf_filter_cmp (
   input  wire caf_pkg::caf_msg_s     msg,      // incoming message
   input  wire caf_pkg::caf_id_s      pattern,  // stored filter pattern
   input  wire caf_pkg::caf_id_s      mask,     // selected acceptance mask
   input  wire caf_pkg::caf_flt_cfg_s cfg,      // filter lane settings
   input  wire logic [4:0]            count,    // clamped data compare count
   output logic                       match     // filter accepts message
);

   logic [17:0] data_bits;
   logic [17:0] data_sel;
   logic        type_ok;
   logic        sid_ok;
   logic        eid_ok;
   logic        data_ok;

   // data stream order: byte 0 bit 7 first, meets extended bit 0 first
   genvar k;
   generate
      for (k = 0; k < 18; k++) begin : g_data
         localparam logic [4:0] K5 = 5'(k);
         assign data_bits[k] = msg.data[23-k];
         assign data_sel[k]  = (count > K5);
      end
   endgenerate

   // identifier type must agree with the filter's type select
   assign type_ok = (pattern.id_type == msg.is_ext);
   // masked bits compare exactly, cleared mask bits are ignored
   assign sid_ok  = (((msg.standard_id_pattern ^ pattern.standard_id_pattern) & mask.standard_id_pattern) == 11'h000);
   assign eid_ok  = !msg.is_ext
                  | (((msg.extended_id_pattern ^ pattern.extended_id_pattern) & mask.extended_id_pattern) == 18'h00000);
   // standard frames may also compare leading data bits to the extended pattern
   assign data_ok = msg.is_ext
                  | (((data_bits ^ pattern.extended_id_pattern) & mask.extended_id_pattern & data_sel) == 18'h00000);
   assign match   = cfg.en & type_ok & sid_ok & eid_ok & data_ok;

endmodule : caf_filter_cmp

// ===== design/caf_acceptance.sv
`timescale 1ns/10ps
// Function
// - halt matching in idle when halt bit set
// - active flag one until fully disabled
// - disable waits for current transaction end
// - count selects data bits compared to extended
// - only enabled filters take part
// - mask choice selects one of four masks
// - fifo choice gives destination fifo number
// - four filter lanes packed per control word
// - filter lane writable only while disabled
// - thirty-two identifier words, one per filter
// - identifier word field layout
// - standard bits must equal stored pattern
// - extended bits must equal stored pattern
// - type select picks standard or extended frames
// - identifier word writable only while disabled
// - unimplemented bits ignore writes, read zero
module caf_acceptance (
   input  wire logic                   clk,           // system clock
   input  wire logic                   reset_n,       // async reset, active low
   input  wire logic                   ce,            // clock enable, freezes all state
   input  wire logic                   psel,          // apb select
   input  wire logic                   penable,       // apb access phase
   input  wire logic                   pwrite,        // apb write
   input  wire logic [11:0]            paddr,         // apb byte address
   input  wire logic [31:0]            pwdata,        // apb write data
   input  wire logic [3:0]             pstrb,         // apb byte strobes
   output logic                        pready,        // apb ready
   output logic [31:0]                 prdata,        // apb read data
   output logic                        pslverr,       // apb error, unmapped address
   input  wire logic                   sys_idle,      // system in idle mode
   input  wire logic                   frame_busy,    // engine transaction in progress
   input  wire logic                   msg_valid,     // message ready, one-cycle pulse
   input  wire caf_pkg::caf_msg_s      msg,           // message identifier and data
   output logic                        res_valid,     // result pulse
   output caf_pkg::caf_result_s        res,           // hit, filter and fifo
   output logic                        module_active  // module still active
);

   caf_pkg::caf_apb_e     state_r;
   caf_pkg::caf_apb_e     state_nxt;
   logic                  pready_r;
   logic [31:0]           prdata_r;
   logic                  pslverr_r;
   logic                  enable_r;
   logic                  halt_r;
   logic [4:0]            count_r;
   logic                  active_r;
   logic                  res_valid_r;
   caf_pkg::caf_result_s  res_r;
   caf_pkg::caf_flt_cfg_s ctl_r [32];
   caf_pkg::caf_id_s      id_r [32];
   caf_pkg::caf_id_s      mask_r [4];

   // merge strobed bytes, then keep only writable bits
   function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb,
                                              input logic [31:0] wmask);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
      merge_word = (old_w & ~m) | (new_w & m);
   endfunction : merge_word

   // lowest set bit index of a match vector
   function automatic logic [4:0] lowest_bit(input logic [31:0] v);
      lowest_bit = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            lowest_bit = 5'(i);
         end
      end
   endfunction : lowest_bit

   // address decode
   wire         aligned   = (paddr[1:0] == 2'h0);
   wire         hit_con   = aligned & (paddr == caf_pkg::OFF_MODULE_CONTROL);
   wire         hit_mask  = aligned & (paddr[11:4] == caf_pkg::OFF_MASK_BASE[11:4]);
   wire         hit_ctl   = aligned & (paddr[11:5] == caf_pkg::OFF_FILTER_CTRL_BASE[11:5]);
   wire         hit_id    = aligned & (paddr[11:7] == caf_pkg::OFF_FILTER_WORD_BASE[11:7]);
   wire         mapped    = hit_con | hit_mask | hit_ctl | hit_id;
   wire  [1:0]  mask_idx  = paddr[3:2];
   wire  [2:0]  ctl_idx   = paddr[4:2];
   wire  [4:0]  id_idx    = paddr[6:2];
   wire         wr_go     = ce & psel & penable & pwrite & pready_r & mapped;

   // control words as seen on the bus, four lanes each
   logic [31:0] ctl_word [8];
   genvar w;
   generate
      for (w = 0; w < 8; w++) begin : g_ctl_word
         assign ctl_word[w] = {ctl_r[4*w+3], ctl_r[4*w+2], ctl_r[4*w+1], ctl_r[4*w]};
      end
   endgenerate

   // module control read image, unused bits read zero
   wire  [31:0] con_word  = {16'h0000, enable_r, 1'b0, halt_r, 1'b0, active_r,
                             6'h00, count_r};
   wire  [31:0] rd_data   = hit_con  ? con_word :
                            hit_mask ? (mask_r[mask_idx] & caf_pkg::MASK_WRITE_MASK) :
                            hit_ctl  ? ctl_word[ctl_idx] :
                            hit_id   ? (id_r[id_idx] & caf_pkg::ID_WRITE_MASK) :
                            32'h0000_0000;

   // bus slave: one wait cycle, then ready with registered data
   assign state_nxt = (state_r == caf_pkg::APB_IDLE && psel && penable) ? caf_pkg::APB_ACK
                                                                         : caf_pkg::APB_IDLE;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r   <= caf_pkg::APB_IDLE;
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         state_r   <= state_nxt;
         pready_r  <= (state_nxt == caf_pkg::APB_ACK);
         prdata_r  <= (state_nxt == caf_pkg::APB_ACK && !pwrite) ? rd_data : 32'h0000_0000;
         pslverr_r <= (state_nxt == caf_pkg::APB_ACK) & !mapped;
      end
   end

   // module control register
   wire  [31:0] con_new = merge_word(con_word, pwdata, pstrb, caf_pkg::CON_WRITE_MASK);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_r <= caf_pkg::CON_ENABLE_RST;
         halt_r   <= caf_pkg::CON_HALT_RST;
         count_r  <= caf_pkg::COUNT_RST;
      end else if (ce && wr_go && hit_con) begin
         enable_r <= con_new[caf_pkg::CON_ENABLE_BIT];
         halt_r   <= con_new[caf_pkg::CON_HALT_IDLE_BIT];
         count_r  <= con_new[caf_pkg::CON_COUNT_LSB +: caf_pkg::COUNT_W];
      end
   end

   // acceptance masks, always writable
   genvar m;
   generate
      for (m = 0; m < 4; m++) begin : g_mask
         wire mask_we = wr_go & hit_mask & (mask_idx == 2'(m));
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               mask_r[m] <= caf_pkg::MASK_WORD_RST;
            end else if (ce && mask_we) begin
               mask_r[m] <= merge_word(mask_r[m], pwdata, pstrb, caf_pkg::MASK_WRITE_MASK);
            end
         end
      end
   endgenerate

   // invalid counts above the limit behave as the limit
   wire  [4:0]  count_eff  = (count_r > caf_pkg::COUNT_MAX) ? caf_pkg::COUNT_MAX : count_r;

   // per filter lane and identifier word, locked while the filter is enabled
   logic [31:0] match_vec;
   genvar f;
   generate
      for (f = 0; f < 32; f++) begin : g_filter
         localparam int LANE = f % 4;
         wire lane_we = wr_go & hit_ctl & (ctl_idx == 3'(f / 4)) & pstrb[LANE]
                      & !ctl_r[f].en;
         wire id_we   = wr_go & hit_id & (id_idx == 5'(f)) & !ctl_r[f].en;
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               ctl_r[f] <= caf_pkg::CTL_LANE_RST;
            end else if (ce && lane_we) begin
               ctl_r[f] <= pwdata[8*LANE +: 8];
            end
         end
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               id_r[f] <= caf_pkg::ID_WORD_RST;
            end else if (ce && id_we) begin
               id_r[f] <= merge_word(id_r[f], pwdata, pstrb, caf_pkg::ID_WRITE_MASK);
            end
         end
         caf_filter_cmp u_cmp (
            .msg     (msg),
            .pattern (id_r[f]),
            .mask    (mask_r[ctl_r[f].mask_choice]),
            .cfg     (ctl_r[f]),
            .count   (count_eff),
            .match   (match_vec[f])
         );
      end
   endgenerate

   // running while enabled or finishing a transaction, not while halted in idle
   wire         halted     = halt_r & sys_idle;
   wire         running    = (enable_r | frame_busy) & !halted;
   wire         run_go     = ce & msg_valid & running;
   wire  [4:0]  win_filter = lowest_bit(match_vec);
   wire         any_hit    = |match_vec;

   // one result per message, lowest matching filter decides the fifo
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         res_valid_r <= 1'b0;
         res_r       <= '0;
      end else if (ce) begin
         res_valid_r <= msg_valid & running;
         if (msg_valid && running) begin
            res_r.hit    <= any_hit;
            res_r.filter <= win_filter;
            res_r.fifo   <= ctl_r[win_filter].destination_fifo_choice;
         end
      end
   end

   // active until disabled and the current transaction has ended
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_r <= 1'b1;
      end else if (ce) begin
         active_r <= enable_r | frame_busy;
      end
   end

   assign pready        = pready_r;
   assign prdata        = prdata_r;
   assign pslverr       = pslverr_r;
   assign res_valid     = res_valid_r;
   assign res           = res_r;
   assign module_active = active_r;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_idle_halt_blocks: assert property (
      (ce && msg_valid && halt_r && sys_idle) |=> !res_valid_r)
      else $error("message accepted while halted in idle");
   a_disable_waits: assert property (
      (ce && !enable_r && frame_busy) |=> active_r)
      else $error("active flag dropped during a transaction");
   a_active_drops: assert property (
      (ce && !enable_r && !frame_busy) ##1 (ce && !enable_r && !frame_busy) |=> !active_r)
      else $error("active flag stuck while disabled");
   a_lane_locked: assert property (
      (ce && ctl_r[2].en) |=> $stable(ctl_r[2]))
      else $error("enabled filter lane changed");
   a_id_locked: assert property (
      ctl_r[2].en |=> $stable(id_r[2]))
      else $error("identifier word changed while filter enabled");
   a_id_rsv_zero: assert property (
      (pready_r && !pwrite && hit_id) |-> (prdata_r[20] == 1'b0 && prdata_r[18] == 1'b0))
      else $error("reserved identifier bit read nonzero");
   a_fifo_routed: assert property (
      (res_valid_r && res_r.hit) |-> (res_r.fifo == ctl_r[res_r.filter].destination_fifo_choice))
      else $error("result fifo differs from filter fifo choice");
   a_lowest_wins: assert property (
      run_go |=> (res_valid_r && res_r.hit == $past(any_hit)
                  && (!res_r.hit || res_r.filter == $past(win_filter))
                  && ($past(match_vec) & ((32'h1 << res_r.filter) - 32'h1)) == 32'h0))
      else $error("result not from lowest matching filter");
   a_type_gate: assert property (
      match_vec[2] |-> (id_r[2].id_type == msg.is_ext && ctl_r[2].en))
      else $error("filter matched wrong identifier type");
   a_apb_wait: assert property (
      (psel && penable && !pready_r && ce) |=> (pready_r ##1 !pready_r))
      else $error("bus answer timing wrong");

   // read images, gating and routing
   a_con_rsv_zero: assert property (
      (pready_r && !pwrite && hit_con) |-> ((prdata_r & 32'hffff_57e0) == 32'h0000_0000))
      else $error("reserved control bit read nonzero");
   a_halt_off_runs: assert property (
      (ce && msg_valid && !halt_r && enable_r) |=> res_valid_r)
      else $error("message dropped while not halted");
   a_disabled_drops: assert property (
      (ce && msg_valid && !enable_r && !frame_busy) |=> !res_valid_r)
      else $error("message accepted while disabled");
   a_disabled_no_match: assert property (
      !ctl_r[1].en |-> !match_vec[1])
      else $error("disabled filter matched");
   a_mask_routed: assert property (
      match_vec[9] |-> (((msg.standard_id_pattern ^ id_r[9].standard_id_pattern) & mask_r[ctl_r[9].mask_choice].standard_id_pattern) == 11'h000))
      else $error("filter matched outside its selected mask");
   a_ce_holds_result: assert property (
      !ce |=> ($stable(res_valid_r) && $stable(res_r)))
      else $error("result changed while clock enable low");

   c_hit: cover property (run_go && any_hit ##1 res_valid_r);
   c_miss: cover property (run_go && !any_hit ##1 res_valid_r && !res_r.hit);
   c_disable_wait: cover property (!enable_r && !frame_busy && active_r ##1 !active_r);
   c_locked_write: cover property (wr_go && hit_id && ctl_r[id_idx].en);
   c_ce_paused: cover property (!ce && msg_valid ##1 ce && !res_valid_r);

endmodule : caf_acceptance

// ===== tb/caf_node_model.sv
`timescale 1ns/10ps
// stands in for the protocol engine that delivers frames from other bus nodes
module caf_node_model (
   input  wire logic         clk,        // system clock
   output caf_pkg::caf_msg_s msg,        // frame identifier and data
   output logic              msg_valid,  // one-cycle frame strobe
   output logic              frame_busy  // transaction in progress
);
   // quiet lines until the first frame
   initial begin
      msg_valid  = 1'b0;
      frame_busy = 1'b0;
      msg        = '0;
   end

   // one frame after some idle cycles, so both prompt and slow traffic occur
   task automatic send(input caf_pkg::caf_msg_s m, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      msg_valid <= 1'b1;
      msg       <= m;
      @(posedge clk);
      msg_valid <= 1'b0;
      msg       <= ~m;  // released lines never keep the old frame
   endtask : send

   // raise or drop the transaction level
   task automatic set_busy(input logic b);
      @(posedge clk);
      frame_busy <= b;
   endtask : set_busy
endmodule : caf_node_model

// ===== tb/caf_acceptance_tb.sv
`timescale 1ns/10ps
module caf_acceptance_tb;
   localparam logic [11:0] CON  = caf_pkg::OFF_MODULE_CONTROL;
   localparam logic [11:0] MSK  = caf_pkg::OFF_MASK_BASE;
   localparam logic [11:0] CTL  = caf_pkg::OFF_FILTER_CTRL_BASE;
   localparam logic [11:0] IDW  = caf_pkg::OFF_FILTER_WORD_BASE;
   localparam logic [10:0] HIT2 = 11'h447;  // filter 2, fifo 7
   localparam logic [10:0] HIT30 = 11'h7c3; // filter 30, fifo 3
   localparam logic [10:0] HIT9 = 11'h52c;  // filter 9, fifo 12
   localparam logic [10:0] HIT5 = 11'h4bf;  // filter 5, fifo 31
   localparam logic [32:0] ERR  = 33'h1_0000_0000;
   logic                 clk, reset_n, ce, psel, penable, pwrite, pready, pslverr;
   logic                 sys_idle, frame_busy, msg_valid, res_valid, module_active;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rdata, r;
   logic [3:0]           pstrb;
   caf_pkg::caf_msg_s    msg;
   caf_pkg::caf_result_s res;
   logic [32:0]          rd_q[$];
   logic [10:0]          res_q[$];
   int                   n_mismatch = 0;
   int                   checks = 0;
   int                   cyc = 0;

   caf_acceptance dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .sys_idle(sys_idle),
      .frame_busy(frame_busy), .msg_valid(msg_valid), .msg(msg), .res_valid(res_valid),
      .res(res), .module_active(module_active));
   caf_node_model node_u (.clk(clk), .msg(msg), .msg_valid(msg_valid),
      .frame_busy(frame_busy));

   // free-running clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task automatic cmp_rd(input logic [32:0] exp, input logic [32:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t read exp %h got %h", $time, exp, got);
      end
   endtask : cmp_rd

   task automatic cmp_res(input logic [10:0] exp, input logic [10:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t result exp %h got %h", $time, exp, got);
      end
   endtask : cmp_res

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rdata = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0, 4'hf);
   endtask : rd

   // one frame; a taken frame notes its expected result first
   task automatic frame(input logic x, input logic [10:0] s, input logic [17:0] e,
                        input logic [23:0] d, input logic take, input logic [10:0] exp);
      if (take)
         res_q.push_back(exp);
      node_u.send({x, s, e, d}, $urandom_range(2));
   endtask : frame

   // watcher: oldest note against each read or result
   always @(posedge clk) begin
      if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0)
         cmp_rd(rd_q.pop_front(), {pslverr, prdata});
      if (res_valid === 1'b1) begin
         if (res_q.size() > 0) begin
            cmp_res(res_q.pop_front(), res);
         end else begin
            n_mismatch++;
            $display("BAD %0t result exp %h got %h", $time, 11'h0, res);
         end
      end
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   // main sequence
   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      sys_idle = 1'b0;
      void'($urandom(32'h0f54));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      rd(CON, 33'h0_0000_8800);
      rd(CTL, 33'h0);
      rd(IDW, 33'h0);
      rd(12'h050, ERR);
      wr(MSK, 32'hffe3_ffff);
      wr(MSK + 12'h004, 32'hffe0_0000);
      wr(MSK + 12'h008, 32'hf003_ffff);
      wr(MSK + 12'h00c, 32'h0);
      rd(MSK, 33'h0_ffe3_ffff);
      wr(IDW + 12'h004, 32'h2460_0000);
      wr(IDW + 12'h008, 32'h2460_0000);
      wr(IDW + 12'h014, 32'h0aaa_a5a5);
      wr(IDW + 12'h024, 32'ha003_ffff);
      wr(IDW + 12'h00c, 32'hffff_ffff);
      rd(IDW + 12'h00c, 33'h0_ffeb_ffff);
      r = $urandom;
      wr(IDW + 12'h07c, r);
      rd(IDW + 12'h07c, {1'b0, r & caf_pkg::ID_WRITE_MASK});
      rd(12'h180, ERR);
      wr(CTL, 32'h00a7_0000);
      wr(CTL + 12'h004, 32'h0000_9f00);
      wr(CTL + 12'h008, 32'h0000_cc00);
      apb(1'b1, CTL + 12'h01c, 32'h5ae3_5a5a, 4'b0100);
      rd(CTL + 12'h01c, 33'h0_00e3_0000);
      wr(IDW + 12'h008, 32'h0);
      wr(CTL, 32'h0);
      rd(IDW + 12'h008, 33'h0_2460_0000);
      rd(CTL, 33'h0_00a7_0000);
      rd(CTL + 12'h004, 33'h0_0000_9f00);
      ce <= 1'b0;
      frame(1'b0, 11'h123, 18'h0, 24'h0, 1'b0, 11'h0);
      ce <= 1'b1;
      r = $urandom;
      frame(1'b0, 11'h123, r[17:0], r[23:0], 1'b1, HIT2);
      frame(1'b0, 11'h122, r[17:0], r[23:0], 1'b1, HIT30);
      frame(1'b0, {4'ha, r[6:0]}, r[17:0], r[23:0], 1'b1, HIT9);
      frame(1'b1, 11'h055, 18'h2a5a5, r[23:0], 1'b1, HIT5);
      frame(1'b1, 11'h055, 18'h2a5a4, r[23:0], 1'b1, 11'h0);
      frame(1'b1, 11'h123, 18'h0, r[23:0], 1'b1, 11'h0);
      wr(CON, 32'h0000_8001);
      frame(1'b0, 11'h500, 18'h0, 24'h7fffff, 1'b1, HIT30);
      frame(1'b0, 11'h500, 18'h0, 24'h800000, 1'b1, HIT9);
      wr(CON, 32'h0000_8012);
      frame(1'b0, 11'h500, 18'h0, 24'hffffc0, 1'b1, HIT9);
      frame(1'b0, 11'h500, 18'h0, 24'hffff80, 1'b1, HIT30);
      wr(CON, 32'hffff_fff2);
      rd(CON, 33'h0_0000_a812);
      sys_idle <= 1'b1;
      frame(1'b0, 11'h123, 18'h0, r[23:0], 1'b0, 11'h0);
      wr(CON, 32'h0000_8000);
      frame(1'b0, 11'h123, 18'h0, r[23:0], 1'b1, HIT2);
      sys_idle <= 1'b0;
      node_u.set_busy(1'b1);
      wr(CON, 32'h0);
      frame(1'b0, 11'h123, 18'h0, r[23:0], 1'b1, HIT2);
      rd(CON, 33'h0_0000_0800);
      node_u.set_busy(1'b0);
      for (int i = 0; i < 20 && rdata[11] !== 1'b0; i++)
         apb(1'b0, CON, 32'h0, 4'hf);
      cmp_rd(33'h0, {32'h0, module_active});
      rd(CON, 33'h0);
      frame(1'b0, 11'h123, 18'h0, r[23:0], 1'b0, 11'h0);
      repeat (6) @(posedge clk);
      cmp_rd(33'h0, {rd_q.size() != 0, 21'h0, res_q.size() != 0, 10'h0});
      close_out();
   end
endmodule : caf_acceptance_tb
